// >>> bus_master_model.sv
// processor-side bus master model for the divider register port
// assumes one clock; the bench calls wr and rd through this instance
`timescale 1ns/100ps

module bus_master_model (
	input  wire logic        clk,
	output logic [4:0]       awaddr,
	output logic             awvalid,
	input  wire logic        awready,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic        bvalid,
	output logic             bready,
	output logic [4:0]       araddr,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic        rvalid,
	output logic             rready
);

	// ==================================================================
	// idle levels at time zero
	// divider clock runs from time zero, so it is enabled before any access
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end

	// ==================================================================
	// one write: address and data offered together, each dropped when taken
	// ready is sampled at the falling edge so the handshake edge is known
	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
		logic ta, td, ad, dd;
		ad = 1'b0;
		dd = 1'b0;
		@(posedge clk);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= s;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		while (!(ad && dd)) begin
			@(negedge clk);
			ta = awvalid && awready;
			td = wvalid && wready;
			@(posedge clk);
			// released lines show a changed value, never the stale one
			if (ta) begin
				awvalid <= 1'b0;
				awaddr  <= ~a;
				ad = 1'b1;
			end
			if (td) begin
				wvalid <= 1'b0;
				wdata  <= ~d;
				wstrb  <= ~s;
				dd = 1'b1;
			end
		end
		bready <= 1'b1;
		do begin
			@(negedge clk);
			ta = bvalid;
			@(posedge clk);
		end while (!ta);
		bready <= 1'b0;
	endtask

	// ==================================================================
	// one read: address held until taken, rready held until rvalid seen
	task automatic rd(input logic [4:0] a);
		logic t;
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		do begin
			@(negedge clk);
			t = arready;
			@(posedge clk);
		end while (!t);
		arvalid <= 1'b0;
		araddr  <= ~a;
		rready  <= 1'b1;
		do begin
			@(negedge clk);
			t = rvalid;
			@(posedge clk);
		end while (!t);
		rready <= 1'b0;
	endtask

endmodule

// >>> hw_divider_map.svh
// register offsets, field positions and reset values of the hardware divider
// assumes a 32-bit register bus with one aligned word per register
`ifndef HW_DIVIDER_MAP_SVH
`define HW_DIVIDER_MAP_SVH

// ==========================================================================
// register byte offsets
`define HWD_OFS_DIVIDEND   5'h00
`define HWD_OFS_DIVISOR    5'h04
`define HWD_OFS_QUOTIENT   5'h08
`define HWD_OFS_REMAINDER  5'h0C
`define HWD_OFS_STATUS     5'h10

// ==========================================================================
// reset values
`define HWD_RST_DIVIDEND   32'h00000000
`define HWD_RST_DIVISOR    16'hFFFF
`define HWD_RST_QUOTIENT   32'h00000000
`define HWD_RST_REMAINDER  32'h00000000
`define HWD_RST_ZERO_FLAG  1'h0
`define HWD_RST_STATUS_B0  1'h1

// ==========================================================================
// field positions
`define HWD_STS_ZERO_BIT   1
`define HWD_STS_RSV0_BIT   0
`define HWD_DIVISOR_MSB    15

// ==========================================================================
// bus answers
`define HWD_RESP_OKAY      2'h0
`define HWD_RESP_SLVERR    2'h2

`endif

// >>> hw_divider_pkg.sv
// types shared by the divider datapath and its register front end
// assumes nothing beyond a standard elaborator
package hw_divider_pkg;

	// ==================================================================
	// operand and result bundles
	typedef struct packed {
		logic [31:0] dividend;   // signed dividend
		logic [15:0] divisor;    // signed divisor
	} div_operands_t;

	typedef struct packed {
		logic [31:0] quotient;   // signed quotient
		logic [31:0] remainder;  // sign-extended remainder
		logic        zero;       // divisor was zero
	} div_result_t;

	// ==================================================================
	// register selection after address decode
	typedef enum logic [2:0] {
		SEL_DIVIDEND  = 3'b000,
		SEL_DIVISOR   = 3'b001,
		SEL_QUOTIENT  = 3'b010,
		SEL_REMAINDER = 3'b011,
		SEL_STATUS    = 3'b100,
		SEL_NONE      = 3'b111
	} reg_sel_t;

endpackage

// >>> signed_div_core.sv
// combinational signed divide of a wide dividend by a narrow divisor
// assumes the caller registers the result; no clock inside
`timescale 1ns/100ps

module signed_div_core #(
	parameter int DW = 32,   // dividend width
	parameter int SW = 16    // divisor width
) (
	input  wire hw_divider_pkg::div_operands_t ops,
	output hw_divider_pkg::div_result_t        res
);

	// ==================================================================
	// widened operands: one extra bit keeps min / -1 from overflowing
	logic signed [DW:0] num;   // sign-extended dividend
	logic signed [DW:0] den;   // sign-extended divisor
	logic signed [DW:0] quo;   // full quotient
	logic signed [DW:0] rem;   // full remainder

	// operands are two's complement values
	assign num = {ops.dividend[DW-1], ops.dividend};
	assign den = {{(DW+1-SW){ops.divisor[SW-1]}}, ops.divisor};

	// ==================================================================
	// truncating divide; remainder follows the dividend's sign
	always_comb begin
		if (den == '0) begin
			// zero divisor: all-ones quotient, dividend low half as remainder
			quo = '1;
			rem = {{(DW+1-SW){ops.dividend[SW-1]}}, ops.dividend[SW-1:0]};
		end else begin
			quo = num / den;
			rem = num % den;
		end
	end

	// ==================================================================
	// result packing; remainder magnitude always fits the divisor width
	assign res.quotient  = quo[DW-1:0];
	assign res.remainder = {{(DW-SW){rem[SW-1]}}, rem[SW-1:0]};
	assign res.zero      = (ops.divisor == '0);

endmodule

// >>> signed_integer_divider.sv
// memory-mapped signed divider behind an axi4-lite slave port
// assumes one clock, an active-low async reset, one master
//
// Contract
// - dividend 32-bit signed, divisor 16-bit signed
// - divisor write starts division automatically
// - results readable one cycle after divisor write
// - quotient is full 32-bit signed value
// - remainder low 16 bits, sign-extended above
// - divisor register holds only low 16 bits
// - status bit 1 flags zero divisor
// - status read-only, other bits reserved
// - quotient held until next division finishes; a write to the quotient register also changes it
`timescale 1ns/100ps
`include "hw_divider_map.svh"

module signed_integer_divider #(
	parameter int AW = 5   // byte address bits decoded
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic [AW-1:0] s_axi_awaddr,
	input  wire logic [2:0]    s_axi_awprot,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [AW-1:0] s_axi_araddr,
	input  wire logic [2:0]    s_axi_arprot,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready
);

	// ==================================================================
	// reset synchroniser
	logic rst_meta_ff;   // first stage, read only by second
	logic rst_sync_ff;   // released reset used everywhere

	// async assert, release after two edges
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	// ==================================================================
	// register state
	logic [31:0] dividend_ff;    // dividend source
	logic [15:0] divisor_ff;     // divisor source, low half only
	logic [31:0] quotient_ff;    // quotient result
	logic [31:0] remainder_ff;   // remainder result
	logic        zero_flag_ff;   // divisor-zero status

	// write channel state
	logic          aw_hold_ff;   // address captured
	logic          w_hold_ff;    // data captured
	logic [AW-1:0] waddr_ff;     // captured write address
	logic [31:0]   wdata_ff;     // captured write data
	logic [3:0]    wstrb_ff;     // captured byte strobes
	logic          awready_ff;
	logic          wready_ff;
	logic          bvalid_ff;
	logic [1:0]    bresp_ff;

	// read channel state
	logic          arready_ff;
	logic          rvalid_ff;
	logic [31:0]   rdata_ff;
	logic [1:0]    rresp_ff;

	// ==================================================================
	// decode helpers
	function automatic hw_divider_pkg::reg_sel_t decode(input logic [AW-1:0] a);
		hw_divider_pkg::reg_sel_t s;
		s = hw_divider_pkg::SEL_NONE;
		unique case (a)
			`HWD_OFS_DIVIDEND:  s = hw_divider_pkg::SEL_DIVIDEND;
			`HWD_OFS_DIVISOR:   s = hw_divider_pkg::SEL_DIVISOR;
			`HWD_OFS_QUOTIENT:  s = hw_divider_pkg::SEL_QUOTIENT;
			`HWD_OFS_REMAINDER: s = hw_divider_pkg::SEL_REMAINDER;
			`HWD_OFS_STATUS:    s = hw_divider_pkg::SEL_STATUS;
			default:            s = hw_divider_pkg::SEL_NONE;
		endcase
		return s;
	endfunction

	// byte-lane merge of write data into an old word
	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] d, input logic [3:0] be);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				m[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return m;
	endfunction

	// ==================================================================
	// write handshake: address and data in either order
	hw_divider_pkg::reg_sel_t wsel;       // decoded write target
	logic                     aw_take;    // address taken this edge
	logic                     w_take;     // data taken this edge
	logic                     do_write;   // commit this edge
	logic                     nxt_aw_hold;
	logic                     nxt_w_hold;
	logic                     nxt_bvalid;

	assign wsel        = decode(waddr_ff);
	assign aw_take     = s_axi_awvalid & awready_ff;
	assign w_take      = s_axi_wvalid & wready_ff;
	assign do_write    = aw_hold_ff & w_hold_ff & ~bvalid_ff;
	assign nxt_aw_hold = (aw_hold_ff | aw_take) & ~do_write;
	assign nxt_w_hold  = (w_hold_ff | w_take) & ~do_write;
	assign nxt_bvalid  = do_write | (bvalid_ff & ~s_axi_bready);

	// write channel flops; ready drops while a write is pending
	always_ff @(posedge clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff  <= 1'b0;
			awready_ff <= 1'b0;
			wready_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= `HWD_RESP_OKAY;
		end else begin
			aw_hold_ff <= nxt_aw_hold;
			w_hold_ff  <= nxt_w_hold;
			awready_ff <= ~nxt_aw_hold & ~nxt_bvalid;
			wready_ff  <= ~nxt_w_hold & ~nxt_bvalid;
			bvalid_ff  <= nxt_bvalid;
			if (do_write) begin
				// status is read-only and unmapped words refuse
				bresp_ff <= (wsel == hw_divider_pkg::SEL_NONE ||
					wsel == hw_divider_pkg::SEL_STATUS) ?
					`HWD_RESP_SLVERR : `HWD_RESP_OKAY;
			end
		end
	end

	// captured address and data payloads
	always_ff @(posedge clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			waddr_ff <= '0;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
		end else begin
			if (aw_take) begin
				waddr_ff <= s_axi_awaddr;
			end
			if (w_take) begin
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
		end
	end

	// ==================================================================
	// divider datapath
	logic [31:0]                   divisor_word;  // divisor word after byte merge
	logic [15:0]                   nxt_divisor;   // divisor after merge
	logic                          start;         // divisor write commits
	hw_divider_pkg::div_operands_t ops;
	hw_divider_pkg::div_result_t   res;

	// only the low half of the write is kept; upper lanes are dropped here
	assign divisor_word = merge({16'h0000, divisor_ff}, wdata_ff, wstrb_ff);
	assign nxt_divisor  = divisor_word[`HWD_DIVISOR_MSB:0];
	assign start = do_write & (wsel == hw_divider_pkg::SEL_DIVISOR);
	// held dividend plus the divisor being written
	assign ops.dividend = dividend_ff;
	assign ops.divisor  = nxt_divisor;

	signed_div_core #(
		.DW (32),
		.SW (16)
	) u_core (
		.ops (ops),
		.res (res)
	);

	// ==================================================================
	// source registers
	always_ff @(posedge clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			dividend_ff <= `HWD_RST_DIVIDEND;
			divisor_ff  <= `HWD_RST_DIVISOR;
		end else if (do_write) begin
			if (wsel == hw_divider_pkg::SEL_DIVIDEND) begin
				dividend_ff <= merge(dividend_ff, wdata_ff, wstrb_ff);
			end
			if (start) begin
				divisor_ff <= nxt_divisor;
			end
		end
	end

	// result registers: loaded on the divisor write edge itself
	always_ff @(posedge clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			quotient_ff  <= `HWD_RST_QUOTIENT;
			remainder_ff <= `HWD_RST_REMAINDER;
		end else if (start) begin
			quotient_ff  <= res.quotient;
			remainder_ff <= res.remainder;
		end else if (do_write) begin
			// results are writable, but only between divisions
			if (wsel == hw_divider_pkg::SEL_QUOTIENT) begin
				quotient_ff <= merge(quotient_ff, wdata_ff, wstrb_ff);
			end
			if (wsel == hw_divider_pkg::SEL_REMAINDER) begin
				remainder_ff <= merge(remainder_ff, wdata_ff, wstrb_ff);
			end
		end
	end

	// zero flag re-evaluated on every divisor write
	always_ff @(posedge clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			zero_flag_ff <= `HWD_RST_ZERO_FLAG;
		end else if (start) begin
			zero_flag_ff <= res.zero;
		end
	end

	// ==================================================================
	// read channel: one word answered per address, registered data
	hw_divider_pkg::reg_sel_t rsel;        // decoded read target
	logic [31:0]              rword;       // selected read word
	logic                     ar_take;
	logic                     nxt_rvalid;

	assign rsel       = decode(s_axi_araddr);
	assign ar_take    = s_axi_arvalid & arready_ff;
	assign nxt_rvalid = ar_take | (rvalid_ff & ~s_axi_rready);

	// read mux; reserved status bits read zero except bit 0, which reads one
	always_comb begin
		rword = 32'h00000000;
		unique case (rsel)
			hw_divider_pkg::SEL_DIVIDEND:  rword = dividend_ff;
			hw_divider_pkg::SEL_DIVISOR:   rword = {16'h0000, divisor_ff};
			hw_divider_pkg::SEL_QUOTIENT:  rword = quotient_ff;
			hw_divider_pkg::SEL_REMAINDER: rword = remainder_ff;
			hw_divider_pkg::SEL_STATUS: begin
				rword[`HWD_STS_ZERO_BIT] = zero_flag_ff;
				rword[`HWD_STS_RSV0_BIT] = `HWD_RST_STATUS_B0;
			end
			hw_divider_pkg::SEL_NONE:      rword = 32'h00000000;
		endcase
	end

	// read channel flops
	always_ff @(posedge clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h00000000;
			rresp_ff   <= `HWD_RESP_OKAY;
		end else begin
			arready_ff <= ~nxt_rvalid;
			rvalid_ff  <= nxt_rvalid;
			if (ar_take) begin
				rdata_ff <= rword;
				rresp_ff <= (rsel == hw_divider_pkg::SEL_NONE) ?
					`HWD_RESP_SLVERR : `HWD_RESP_OKAY;
			end
		end
	end

	// ==================================================================
	// outputs, all straight from flops
	assign s_axi_awready = awready_ff;
	assign s_axi_wready  = wready_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

	// ==================================================================
	// assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_sync_ff);

	// reference values for the checks below
	logic signed [32:0] ref_q;   // reference quotient
	logic signed [32:0] ref_r;   // reference remainder
	assign ref_q = $signed({dividend_ff[31], dividend_ff}) /
		$signed({{17{nxt_divisor[15]}}, nxt_divisor});
	assign ref_r = $signed({dividend_ff[31], dividend_ff}) %
		$signed({{17{nxt_divisor[15]}}, nxt_divisor});

	property p_start_quot;
		start && nxt_divisor != 16'h0000 |=> quotient_ff == $past(ref_q[31:0]);
	endproperty
	a_start_quot: assert property (p_start_quot) else $error("quotient wrong");

	property p_start_rem;
		start && nxt_divisor != 16'h0000 |=>
			remainder_ff[15:0] == $past(ref_r[15:0]);
	endproperty
	a_start_rem: assert property (p_start_rem) else $error("remainder wrong");

	// software may write an unextended remainder, so only a division is checked
	property p_rem_sext;
		start |=> remainder_ff[31:16] == {16{remainder_ff[15]}};
	endproperty
	a_rem_sext: assert property (p_rem_sext) else $error("no sign extension");

	property p_zero_flag;
		start |=> zero_flag_ff == (divisor_ff == 16'h0000);
	endproperty
	a_zero_flag: assert property (p_zero_flag) else $error("zero flag stale");

	property p_status_hold;
		!start |=> $stable(zero_flag_ff);
	endproperty
	a_status_hold: assert property (p_status_hold) else $error("status moved");

	property p_quot_hold;
		!do_write |=> $stable(quotient_ff) && $stable(remainder_ff);
	endproperty
	a_quot_hold: assert property (p_quot_hold) else $error("result changed");

	property p_start_cause;
		$changed(divisor_ff) |-> $past(start);
	endproperty
	a_start_cause: assert property (p_start_cause) else $error("divisor moved");

	property p_rd_divisor;
		ar_take && rsel == hw_divider_pkg::SEL_DIVISOR |=> rdata_ff[31:16] == 16'h0000;
	endproperty
	a_rd_divisor: assert property (p_rd_divisor) else $error("divisor high");

	property p_result_soon;
		start ##1 (s_axi_arvalid && arready_ff &&
			rsel == hw_divider_pkg::SEL_QUOTIENT) |=>
			rdata_ff == quotient_ff;
	endproperty
	a_result_soon: assert property (p_result_soon) else $error("late result");

	property p_bresp_time;
		aw_hold_ff && w_hold_ff && !bvalid_ff |=> bvalid_ff;
	endproperty
	a_bresp_time: assert property (p_bresp_time) else $error("no write answer");

	c_div: cover property (start ##[1:20] (rvalid_ff && s_axi_rready));
	c_zero: cover property (start && nxt_divisor == 16'h0000);
	c_neg: cover property (start && dividend_ff[31] && !nxt_divisor[15]);
	c_err: cover property (rvalid_ff && rresp_ff == `HWD_RESP_SLVERR);

endmodule

// >>> tb_signed_integer_divider.sv
// self-checking bench for the signed divider register port
// assumes the design files and the bus master model compile first
`timescale 1ns/100ps
`include "hw_divider_map.svh"

module tb_signed_integer_divider;

	// ==================================================================
	// constants and notes
	localparam logic [1:0] OK    = `HWD_RESP_OKAY;
	localparam logic [1:0] ERR   = `HWD_RESP_SLVERR;
	localparam logic [4:0] A_DVD = `HWD_OFS_DIVIDEND;
	localparam logic [4:0] A_DVS = `HWD_OFS_DIVISOR;
	localparam logic [4:0] A_QUO = `HWD_OFS_QUOTIENT;
	localparam logic [4:0] A_STS = `HWD_OFS_STATUS;
	localparam int         LIMIT = 6000;   // well above the ~700 cycles needed

	typedef struct packed {
		logic [31:0] data;   // expected read data
		logic [1:0]  resp;   // expected response
		logic        rd;     // set for a read
	} note_t;

	logic        clk;
	logic        rst_n;
	wire  [4:0]  awaddr, araddr;
	wire  [31:0] wdata, rdata;
	wire  [3:0]  wstrb;
	wire  [1:0]  bresp, rresp;
	wire         awvalid, awready, wvalid, wready, bvalid, bready;
	wire         arvalid, arready, rvalid, rready;
	note_t       notes[$];      // expected results, oldest first
	note_t       mon_note;      // note being compared
	int          mismatches;
	int          check_count;
	int          cycles;
	logic [31:0] seed;          // xorshift state

	// ==================================================================
	// design and bus master
	signed_integer_divider u_signed_integer_divider (
		.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));

	bus_master_model u_bus_master_model (
		.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rvalid(rvalid), .rready(rready));

	// ==================================================================
	// clock and hang guard
	always #5 clk = ~clk;

	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			mismatches++;
			close_out();
		end
	end

	// ==================================================================
	// helpers
	task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (exp !== got) begin
			$display("wrong value %s expected %h seen %h", name, exp, got);
			mismatches++;
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	// truncating signed divide; zero divisor per the chosen fill values
	function automatic logic [63:0] ref_div(input logic [31:0] n, input logic [15:0] d);
		logic signed [31:0] sn;
		logic signed [31:0] sd;
		sn = n;
		sd = {{16{d[15]}}, d};
		if (d == 16'h0)
			return {32'hFFFFFFFF, {16{n[15]}}, n[15:0]};
		if (d == 16'hFFFF)
			return {-n, 32'h0};
		return {sn / sd, sn % sd};
	endfunction

	task automatic wr_chk(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] r);
		notes.push_back('{32'h0, r, 1'b0});
		u_bus_master_model.wr(a, d, s);
	endtask

	task automatic rd_chk(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
		notes.push_back('{d, r, 1'b1});
		u_bus_master_model.rd(a);
	endtask

	// dividend first, then divisor launches; results read straight after
	task automatic divide(input logic [31:0] n, input logic [31:0] dw);
		logic [63:0] e;
		e = ref_div(n, dw[15:0]);
		wr_chk(A_DVD, n, 4'hF, OK);
		wr_chk(A_DVS, dw, 4'hF, OK);
		rd_chk(A_QUO, e[63:32], OK);
		rd_chk(`HWD_OFS_REMAINDER, e[31:0], OK);
		rd_chk(A_STS, {30'h0, dw[15:0] == 16'h0, 1'b1}, OK);
		rd_chk(A_DVS, {16'h0, dw[15:0]}, OK);
	endtask

	// ==================================================================
	// monitor: each response handshake takes the oldest note
	always @(negedge clk) begin
		if (rst_n && ((bvalid && bready) || (rvalid && rready))) begin
			cmp("pending note", 32'h1, {31'h0, notes.size() != 0});
			mon_note = notes.pop_front();
			cmp("channel", {31'h0, mon_note.rd}, {31'h0, rvalid});
			cmp("response", {30'h0, mon_note.resp}, {30'h0, rvalid ? rresp : bresp});
			if (mon_note.rd)
				cmp("read data", mon_note.data, rdata);
		end
	end

	// ==================================================================
	// main sequence
	localparam logic [31:0] RST_TAB [5] = '{32'h0, 32'h0000FFFF, 32'h0, 32'h0, 32'h1};
	localparam logic [63:0] CASES [7] = '{
		{32'h80000000, 32'h0000FFFF}, {32'h00000007, 32'h0000FFFE},
		{32'hFFFFFFF9, 32'h00000002}, {32'h12345678, 32'h00000000},
		{32'h8000F123, 32'hFFFF0000}, {32'h00000064, 32'hABCD0007},
		{32'hFFFF8000, 32'h00008000}};

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		mismatches = 0;
		check_count = 0;
		cycles = 0;
		seed = 32'd56899;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 5; i++)
			rd_chk(5'(4 * i), RST_TAB[i], OK);
		$display("test reset values done");
		for (int i = 0; i < 7; i++)
			divide(CASES[i][63:32], CASES[i][31:0]);
		$display("test boundary divisions done");
		for (int i = 0; i < 24; i++) begin
			seed = xs(seed);
			mon_note.data = seed;
			seed = xs(seed);
			divide(mon_note.data, seed);
		end
		$display("test random divisions done");
		// quotient read issued so it is taken the edge after the divisor commits
		wr_chk(A_DVD, 32'd1000, 4'hF, OK);
		fork
			wr_chk(A_DVS, 32'd7, 4'hF, OK);
			begin
				repeat (2) @(posedge clk);
				rd_chk(A_QUO, 32'd142, OK);
			end
		join
		$display("test early result read done");
		divide(32'd1000, 32'd7);
		wr_chk(A_DVD, 32'd5, 4'hF, OK);
		rd_chk(A_QUO, 32'd142, OK);
		wr_chk(A_QUO, 32'hA5A5A5A5, 4'h5, OK);
		rd_chk(A_QUO, 32'h00A500A5, OK);
		$display("test hold and strobes done");
		wr_chk(A_STS, 32'hFFFFFFFF, 4'hF, ERR);
		rd_chk(A_STS, 32'h1, OK);
		wr_chk(5'h14, 32'h1, 4'hF, ERR);
		rd_chk(5'h14, 32'h0, ERR);
		$display("test refusals done");
		close_out();
	end

endmodule
